// ---- rtl/pin_routing_pkg.sv ----
/*
  Constants for the port A pin routing block: register offsets, field
  positions, reset values, pin positions of the shared functions and the
  timer mode and pin-function encodings.
  Assumes a byte-wide register port with a three-bit address.
*/
package pin_routing_pkg;
  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [2:0] ADDR_REMAP = 3'h0;
  localparam logic [2:0] ADDR_DATA = 3'h1;
  localparam logic [2:0] ADDR_DIR = 3'h2;
  localparam logic [2:0] ADDR_WAKE = 3'h3;
  // ----------------------------------------------------------------------
  // remap_control_reg fields, port register mask and reset values
  // ----------------------------------------------------------------------
  localparam int SERIAL_DATA_SEL_BIT = 0;
  localparam int SERIAL_CLOCK_SEL_BIT = 1;
  localparam int TRUE_OUT_EN_BIT = 6;
  localparam int INV_OUT_EN_BIT = 7;
  localparam logic [7:0] REMAP_MASK = 8'hC3;
  localparam logic [7:0] REMAP_RESET = 8'h00;
  localparam logic [7:0] PORT_MASK = 8'h9F;
  localparam logic [7:0] DATA_RESET = 8'hFF;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] WAKE_RESET = 8'h00;
  // ----------------------------------------------------------------------
  // pin positions of the shared functions
  // ----------------------------------------------------------------------
  localparam int PIN_SDA_DEF = 0;
  localparam int PIN_SDA_ALT = 4;
  localparam int PIN_SCK_DEF = 2;
  localparam int PIN_SCK_ALT = 7;
  localparam int PIN_TRUE_OUT = 7;
  localparam int PIN_INV_OUT = 2;
  localparam int PIN_EXT_CLK = 3;
  localparam int PIN_CAPTURE = 1;
  // ----------------------------------------------------------------------
  // timer encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] FUNC_CMP_LOW = 2'h1;
  localparam logic [1:0] FUNC_CMP_HIGH = 2'h2;
  localparam logic [1:0] FUNC_CMP_TOGGLE = 2'h3;
  localparam logic [1:0] FUNC_PWM_INACTIVE = 2'h0;
  localparam logic [1:0] FUNC_PWM_ACTIVE = 2'h1;
  localparam logic [1:0] FUNC_PWM_WAVE = 2'h2;
  localparam logic [1:0] FUNC_PWM_PULSE = 2'h3;
  localparam logic [1:0] FUNC_CAP_RISE = 2'h0;
  localparam logic [1:0] FUNC_CAP_FALL = 2'h1;
  localparam logic [2:0] CLKSEL_EXT_RISE = 3'h6;
  localparam logic [2:0] CLKSEL_EXT_FALL = 3'h7;
endpackage

// ---- rtl/timer_and_serial_pin_routing.sv ----
/*
  Port A pin routing for the timer unit and the serial module, with the
  port data, direction and wake-up registers and the timer pin stages.
  Assumes pin inputs already synchronous to sys_clk and a timer core and
  serial core that sit beside this block on the same clock.
*/
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/10ps
module timer_and_serial_pin_routing
  import pin_routing_pkg::*;
#(
  parameter int ADDR_W = 3
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic bit_set_stb,
  input wire logic bit_clr_stb,
  input wire logic [2:0] bit_idx,
  output logic [7:0] rdata,
  // port A pins
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  // serial core
  input wire logic ser_enable,
  input wire logic ser_sck_o,
  input wire logic ser_sck_oe,
  input wire logic ser_sda_o,
  input wire logic ser_sda_oe,
  output logic ser_sck_i,
  output logic ser_sda_i,
  // timer core
  input wire logic [1:0] tm_mode,
  input wire logic [1:0] tm_pin_func,
  input wire logic [2:0] tm_clk_sel,
  input wire logic tm_cap_from_clk,
  input wire logic tm_init_level,
  input wire logic tm_start,
  input wire logic tm_match_a,
  input wire logic tm_match_p,
  input wire logic tm_pwm_wave,
  input wire logic tm_pulse_wave,
  output logic tm_ext_tick,
  output logic tm_pulse_trigger,
  output logic tm_capture,
  output logic tm_int_a,
  output logic tm_int_p,
  // power management
  input wire logic sleeping,
  output logic wake_req
);

  if (ADDR_W < 3)
  begin : g_chk
    $error("ADDR_W must be at least 3");
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] remap_ff, data_ff, dir_ff, wake_en_ff;
  logic [7:0] prev_in_ff, rdata_ff, pa_out_ff, pa_oe_ff;
  logic tm_level_ff, nxt_tm_level, tick_ff, trig_ff;
  logic cap_ff, int_a_ff, int_p_ff, wake_ff;
  // ----------------------------------------------------------------------
  // register decode and read-modify-write
  // ----------------------------------------------------------------------
  wire logic [2:0] reg_sel = addr[2:0];
  wire logic hi_zero = (ADDR_W == 3) ? 1'b1 : (addr >> 3) == '0;
  wire logic sel_remap = hi_zero && reg_sel == ADDR_REMAP;
  wire logic sel_data = hi_zero && reg_sel == ADDR_DATA;
  wire logic sel_dir = hi_zero && reg_sel == ADDR_DIR;
  wire logic sel_wake = hi_zero && reg_sel == ADDR_WAKE;
  // inputs read the pin, outputs read their own latch
  wire logic [7:0] port_view = ((dir_ff & pa_in) | (~dir_ff & data_ff)) & PORT_MASK;
  wire logic [7:0] rd_val = sel_remap ? remap_ff & REMAP_MASK :
                            sel_data ? port_view :
                            sel_dir ? dir_ff :
                            sel_wake ? wake_en_ff : 8'h00;
  wire logic [7:0] bit_mask = 8'h01 << bit_idx;
  // a bit op on the data latch copies input pin levels into it as well
  wire logic [7:0] wr_val = bit_set_stb ? (rd_val | bit_mask) :
                            bit_clr_stb ? (rd_val & ~bit_mask) :
                            wdata;
  wire logic wr_any = wr_stb | bit_set_stb | bit_clr_stb;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      remap_ff <= REMAP_RESET;
      data_ff <= DATA_RESET & PORT_MASK;
      dir_ff <= DIR_RESET & PORT_MASK;
      wake_en_ff <= WAKE_RESET;
      rdata_ff <= 8'h00;
    end
    else
    begin
      if (wr_any && sel_remap)
        remap_ff <= wr_val & REMAP_MASK;
      if (wr_any && sel_data)
        data_ff <= wr_val & PORT_MASK;
      if (wr_any && sel_dir)
        dir_ff <= wr_val & PORT_MASK;
      if (wr_any && sel_wake)
        wake_en_ff <= wr_val & PORT_MASK;
      rdata_ff <= rd_stb ? rd_val : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // timer output stage
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_tm_level = tm_level_ff;
    if (tm_start)
      nxt_tm_level = tm_init_level;
    else
    begin
      case (tm_mode)
        MODE_COMPARE:
        begin
          if (tm_match_a)
          begin
            case (tm_pin_func)
              FUNC_CMP_LOW: nxt_tm_level = 1'b0;
              FUNC_CMP_HIGH: nxt_tm_level = 1'b1;
              FUNC_CMP_TOGGLE: nxt_tm_level = ~tm_level_ff;
              default: nxt_tm_level = tm_level_ff;
            endcase
          end
        end
        MODE_PWM:
        begin
          case (tm_pin_func)
            FUNC_PWM_INACTIVE: nxt_tm_level = tm_init_level;
            FUNC_PWM_ACTIVE: nxt_tm_level = ~tm_init_level;
            FUNC_PWM_WAVE: nxt_tm_level = tm_pwm_wave;
            FUNC_PWM_PULSE: nxt_tm_level = tm_pulse_wave;
            default: nxt_tm_level = tm_level_ff;
          endcase
        end
        default: nxt_tm_level = tm_level_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // timer input edges and events
  // ----------------------------------------------------------------------
  wire logic clk_rise = pa_in[PIN_EXT_CLK] & ~prev_in_ff[PIN_EXT_CLK];
  wire logic clk_fall = ~pa_in[PIN_EXT_CLK] & prev_in_ff[PIN_EXT_CLK];
  wire logic cap_src = tm_cap_from_clk ? pa_in[PIN_EXT_CLK] : pa_in[PIN_CAPTURE];
  wire logic cap_prev = tm_cap_from_clk ? prev_in_ff[PIN_EXT_CLK] : prev_in_ff[PIN_CAPTURE];
  wire logic cap_rise = cap_src & ~cap_prev;
  wire logic cap_fall = ~cap_src & cap_prev;
  wire logic nxt_tick = (tm_clk_sel == CLKSEL_EXT_RISE && clk_rise) ||
                        (tm_clk_sel == CLKSEL_EXT_FALL && clk_fall);
  wire logic nxt_trig = tm_mode == MODE_PWM && tm_pin_func == FUNC_PWM_PULSE && clk_rise;
  wire logic cap_edge = (tm_pin_func == FUNC_CAP_RISE) ? cap_rise :
                        (tm_pin_func == FUNC_CAP_FALL) ? cap_fall :
                        (cap_rise | cap_fall);
  wire logic nxt_cap = tm_mode == MODE_CAPTURE && cap_edge;
  wire logic nxt_wake = sleeping && |(wake_en_ff & prev_in_ff & ~pa_in);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tm_level_ff <= 1'b0;
      prev_in_ff <= 8'h00;
      tick_ff <= 1'b0;
      trig_ff <= 1'b0;
      cap_ff <= 1'b0;
      int_a_ff <= 1'b0;
      int_p_ff <= 1'b0;
      wake_ff <= 1'b0;
    end
    else
    begin
      tm_level_ff <= nxt_tm_level;
      prev_in_ff <= pa_in;
      tick_ff <= nxt_tick;
      trig_ff <= nxt_trig;
      cap_ff <= nxt_cap;
      int_a_ff <= tm_match_a;
      int_p_ff <= tm_match_p;
      wake_ff <= nxt_wake;
    end
  end

  // ----------------------------------------------------------------------
  // pin routing
  // ----------------------------------------------------------------------
  wire logic sck_alt = remap_ff[SERIAL_CLOCK_SEL_BIT];
  wire logic sda_alt = remap_ff[SERIAL_DATA_SEL_BIT];
  wire logic [7:0] mux_o;
  wire logic [7:0] mux_oe;

  for (genvar i = 0; i < 8; i++)
  begin : g_pin
    wire logic sck_here = ser_enable && (sck_alt ? (i == PIN_SCK_ALT) : (i == PIN_SCK_DEF));
    wire logic sda_here = ser_enable && (sda_alt ? (i == PIN_SDA_ALT) : (i == PIN_SDA_DEF));
    wire logic tp_here = (i == PIN_TRUE_OUT) && remap_ff[TRUE_OUT_EN_BIT];
    wire logic tpb_here = (i == PIN_INV_OUT) && remap_ff[INV_OUT_EN_BIT];
    // timer sits right of serial in every shared list, so it is tested first
    assign mux_o[i] = tpb_here ? ~tm_level_ff :
                      tp_here ? tm_level_ff :
                      sck_here ? ser_sck_o :
                      sda_here ? ser_sda_o :
                      data_ff[i];
    assign mux_oe[i] = (tpb_here || tp_here) ? 1'b1 :
                       sck_here ? ser_sck_oe :
                       sda_here ? ser_sda_oe :
                       ~dir_ff[i] & PORT_MASK[i];
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pa_out_ff <= 8'h00;
      pa_oe_ff <= 8'h00;
    end
    else
    begin
      pa_out_ff <= mux_o;
      pa_oe_ff <= mux_oe;
    end
  end

  // idle-high when the serial module owns no pin
  assign ser_sck_i = !ser_enable ? 1'b1 :
                     sck_alt ? pa_in[PIN_SCK_ALT] : pa_in[PIN_SCK_DEF];
  assign ser_sda_i = !ser_enable ? 1'b1 :
                     sda_alt ? pa_in[PIN_SDA_ALT] : pa_in[PIN_SDA_DEF];
  assign pa_out = pa_out_ff;
  assign pa_oe = pa_oe_ff;
  assign rdata = rdata_ff;
  assign tm_ext_tick = tick_ff;
  assign tm_pulse_trigger = trig_ff;
  assign tm_capture = cap_ff;
  assign tm_int_a = int_a_ff;
  assign tm_int_p = int_p_ff;
  assign wake_req = wake_ff;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_sck_default;
    ser_enable && !sck_alt && !remap_ff[INV_OUT_EN_BIT] |=>
      pa_out[PIN_SCK_DEF] == $past(ser_sck_o) && pa_oe[PIN_SCK_DEF] == $past(ser_sck_oe);
  endproperty
  a_sck_default: assert property (p_sck_default) else $error("sck not on bit 2");
  property p_sda_in;
    ser_enable |-> ser_sda_i == (sda_alt ? pa_in[PIN_SDA_ALT] : pa_in[PIN_SDA_DEF]);
  endproperty
  a_sda_in: assert property (p_sda_in) else $error("serial data from wrong pin");
  property p_inv_out;
    remap_ff[INV_OUT_EN_BIT] |=> pa_oe[PIN_INV_OUT] && pa_out[PIN_INV_OUT] == !$past(tm_level_ff);
  endproperty
  a_inv_out: assert property (p_inv_out) else $error("inverted output wrong");
  property p_tp_wins;
    remap_ff[TRUE_OUT_EN_BIT] && ser_enable && sck_alt |=>
      pa_oe[PIN_TRUE_OUT] && pa_out[PIN_TRUE_OUT] == $past(tm_level_ff);
  endproperty
  a_tp_wins: assert property (p_tp_wins) else $error("timer lost pin priority");
  property p_remap_read;
    rd_stb && sel_remap |=> rdata[5:2] == 4'h0;
  endproperty
  a_remap_read: assert property (p_remap_read) else $error("reserved bits not zero");
  property p_reset_val;
    disable iff (1'b0) srst |=> data_ff == PORT_MASK && dir_ff == PORT_MASK && pa_oe == 8'h00;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("reset values wrong");
  property p_bit_set;
    bit_set_stb && sel_data |=> data_ff == (($past(port_view) | $past(bit_mask)) & PORT_MASK);
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set not read-modify-write");
  property p_wake;
    sleeping && (wake_en_ff & prev_in_ff & ~pa_in) != 8'h00 |=> wake_req ##1 !wake_req || sleeping;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not raised");
  property p_toggle;
    tm_mode == MODE_COMPARE && tm_pin_func == FUNC_CMP_TOGGLE && tm_match_a && !tm_start
      |=> tm_level_ff != $past(tm_level_ff);
  endproperty
  a_toggle: assert property (p_toggle) else $error("compare toggle missing");
  property p_fall_tick;
    tm_clk_sel == CLKSEL_EXT_FALL && clk_fall |=> tm_ext_tick;
  endproperty
  a_fall_tick: assert property (p_fall_tick) else $error("falling tick missing");
  property p_int_split;
    tm_match_a && !tm_match_p |=> tm_int_a && !tm_int_p;
  endproperty
  a_int_split: assert property (p_int_split) else $error("interrupts not separate");
  property p_cov_remap;
    wr_stb && sel_remap ##1 sck_alt && sda_alt;
  endproperty
  c_cov_remap: cover property (p_cov_remap);
  property p_cov_wake;
    sleeping ##1 wake_req;
  endproperty
  c_cov_wake: cover property (p_cov_wake);
  property p_cov_capture;
    tm_mode == MODE_CAPTURE ##1 tm_capture;
  endproperty
  c_cov_capture: cover property (p_cov_capture);
endmodule // timer_and_serial_pin_routing

// ---- verification/pin_world_model.sv ----
/*
  Model of the circuitry that sits on the port A pins.
  Assumes the bench supplies the outside drive levels and their enables.
*/
`timescale 1ns/10ps
module pin_world_model
(
  // clock
  input wire logic sys_clk,
  // device side
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  // outside drivers
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // resolved pin levels
  output logic [7:0] pa_in
);
  logic [7:0] last_ff;

  // a floating pin flips every cycle so a stale level never looks valid
  always_ff @(posedge sys_clk)
    last_ff <= pa_in;

  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_en & ext_val) | (~pa_oe & ~ext_en & ~last_ff);
endmodule // pin_world_model

// ---- verification/timer_and_serial_pin_routing_test.sv ----
/*
  Self-checking bench for the port A pin routing block.
  Assumes the routing package and the pin model are compiled first.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
  end
module timer_and_serial_pin_routing_test;
  import pin_routing_pkg::*;
  logic sys_clk = 1'b0, srst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  logic bit_set_stb = 1'b0, bit_clr_stb = 1'b0, sleeping = 1'b0, a;
  logic [2:0] addr = 3'h0, bit_idx = 3'h0, tm_clk_sel = 3'h0, i, j;
  logic [7:0] wdata = 8'h00, ext_val = 8'hFF, ext_en = 8'hFF, rv, v;
  logic ser_enable = 1'b0, ser_sck_o = 1'b0, ser_sck_oe = 1'b0;
  logic ser_sda_o = 1'b0, ser_sda_oe = 1'b0, tm_cap_from_clk = 1'b0;
  logic [1:0] tm_mode = 2'h3, tm_pin_func = 2'h0;
  logic tm_init_level = 1'b1, tm_start = 1'b0, tm_match_a = 1'b0, tm_match_p = 1'b0;
  logic tm_pwm_wave = 1'b0, tm_pulse_wave = 1'b0;
  logic [7:0] rdata, pa_out, pa_oe, pa_in;
  logic ser_sck_i, ser_sda_i, tm_ext_tick, tm_pulse_trigger, tm_capture;
  logic tm_int_a, tm_int_p, wake_req;
  int mismatches = 0, total_checks = 0, cyc = 0, n, dp, cp, pi, pj, k;
  int pins[6] = '{0, 1, 2, 3, 4, 7};
  wire [5:0] evs = {wake_req, tm_int_p, tm_int_a, tm_capture, tm_pulse_trigger, tm_ext_tick};

  timer_and_serial_pin_routing #(.ADDR_W(3)) i_dut (.sys_clk(sys_clk), .srst(srst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .bit_set_stb(bit_set_stb),
    .bit_clr_stb(bit_clr_stb), .bit_idx(bit_idx), .rdata(rdata), .pa_in(pa_in),
    .pa_out(pa_out), .pa_oe(pa_oe), .ser_enable(ser_enable), .ser_sck_o(ser_sck_o),
    .ser_sck_oe(ser_sck_oe), .ser_sda_o(ser_sda_o), .ser_sda_oe(ser_sda_oe),
    .ser_sck_i(ser_sck_i), .ser_sda_i(ser_sda_i), .tm_mode(tm_mode), .tm_pin_func(tm_pin_func),
    .tm_clk_sel(tm_clk_sel), .tm_cap_from_clk(tm_cap_from_clk), .tm_init_level(tm_init_level),
    .tm_start(tm_start), .tm_match_a(tm_match_a), .tm_match_p(tm_match_p),
    .tm_pwm_wave(tm_pwm_wave), .tm_pulse_wave(tm_pulse_wave), .tm_ext_tick(tm_ext_tick),
    .tm_pulse_trigger(tm_pulse_trigger), .tm_capture(tm_capture), .tm_int_a(tm_int_a),
    .tm_int_p(tm_int_p), .sleeping(sleeping), .wake_req(wake_req));

  pin_world_model i_pins (.sys_clk(sys_clk), .pa_out(pa_out), .pa_oe(pa_oe),
    .ext_val(ext_val), .ext_en(ext_en), .pa_in(pa_in));

  always #4 sys_clk = ~sys_clk;

  // -----------------------------------------------------------------
  // bus and stimulus tasks
  // -----------------------------------------------------------------
  // k: 0 write, 1 bit set, 2 bit clear; bit number rides in d[2:0]
  task automatic acc(input logic [1:0] k, input logic [2:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= ad;
    wdata <= d;
    bit_idx <= d[2:0];
    {bit_clr_stb, bit_set_stb, wr_stb} <= {k == 2'h2, k == 2'h1, k == 2'h0};
    @(posedge sys_clk);
    {bit_clr_stb, bit_set_stb, wr_stb} <= 3'h0;
  endtask

  task automatic rd(input logic [2:0] ad, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= ad;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask

  // counts one-cycle pulses of an event output; ends on an edge
  task automatic watch(input int sel, output int cnt);
    cnt = 0;
    repeat (4)
    begin
      @(posedge sys_clk);
      #1;
      if (evs[sel] !== 1'b0)
        cnt++;
    end
    @(posedge sys_clk);
  endtask

  task automatic pin_ev(input int pin, input logic lvl, input int sel, input int e);
    ext_val[pin] <= lvl;
    watch(sel, n);
    `CHK("event count", e, n)
  endtask

  // w = {match_p, match_a, start}; interrupts follow matches one cycle later
  task automatic tm_pulse(input logic [1:0] m, input logic [1:0] f, input logic [2:0] w,
                          input logic pw);
    @(posedge sys_clk);
    tm_mode <= m;
    tm_pin_func <= f;
    tm_pwm_wave <= pw;
    tm_pulse_wave <= ~pw;
    {tm_match_p, tm_match_a, tm_start} <= w;
    @(posedge sys_clk);
    {tm_match_p, tm_match_a, tm_start} <= 3'h0;
    #1;
    `CHK("timer irq", w[2:1], {tm_int_p, tm_int_a})
    @(posedge sys_clk);
  endtask

  // serial clock is driven opposite so a lost priority shows on pin 7
  task automatic tchk(input logic lvl);
    ser_sck_o <= ~lvl;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("timer pins", {2'h3, lvl, ~lvl}, {pa_oe[7], pa_oe[2], pa_out[7], pa_out[2]})
    @(posedge sys_clk);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h98F1A02D));
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    #1;
    `CHK("oe after reset", 8'h00, pa_oe)
    rd(ADDR_REMAP, rv);
    `CHK("remap reset", REMAP_RESET, rv)
    rd(ADDR_DIR, rv);
    `CHK("dir reset", DIR_RESET & PORT_MASK, rv)
    acc(2'h2, ADDR_DIR, 8'h04);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("first output", 2'h3, {pa_oe[4], pa_out[4]})
    rd(ADDR_DATA, rv);
    `CHK("data reset", DATA_RESET & PORT_MASK, rv)
    acc(2'h0, ADDR_DIR, 8'h00);
    v = 8'($urandom);
    i = 3'($urandom);
    j = 3'($urandom);
    acc(2'h0, ADDR_DATA, v);
    acc(2'h1, ADDR_DATA, {5'h00, i});
    rd(ADDR_DATA, rv);
    `CHK("bit set", (v | (8'h01 << i)) & PORT_MASK, rv)
    acc(2'h2, ADDR_DATA, {5'h00, j});
    rd(ADDR_DATA, rv);
    v = (v | (8'h01 << i)) & ~(8'h01 << j) & PORT_MASK;
    `CHK("bit clear", v, rv)
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("port drive", v, pa_out & PORT_MASK)
    acc(2'h0, ADDR_DIR, 8'hFF);
    v = 8'($urandom) | 8'h3C;
    acc(2'h0, ADDR_REMAP, v);
    rd(ADDR_REMAP, rv);
    `CHK("remap readback", v & REMAP_MASK, rv)
    acc(2'h0, 3'h5, 8'hFF);
    rd(3'h5, rv);
    `CHK("unmapped read", 8'h00, rv)
    for (int s = 0; s < 4; s++)
    begin
      acc(2'h0, ADDR_REMAP, 8'(s));
      a = 1'($urandom);
      dp = s[0] ? PIN_SDA_ALT : PIN_SDA_DEF;
      cp = s[1] ? PIN_SCK_ALT : PIN_SCK_DEF;
      ser_enable <= 1'b1;
      ser_sda_oe <= 1'b1;
      ser_sck_oe <= 1'b1;
      ser_sda_o <= a;
      ser_sck_o <= ~a;
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("sda pin", {1'b1, a}, {pa_oe[dp], pa_out[dp]})
      `CHK("sck pin", {1'b1, ~a}, {pa_oe[cp], pa_out[cp]})
      `CHK("free pins", 2'h0, {pa_oe[4 - dp], pa_oe[9 - cp]})
      @(posedge sys_clk);
      ser_sda_oe <= 1'b0;
      ext_val[dp] <= ~a;
      ext_val[4 - dp] <= a;
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("sda in", ~a, ser_sda_i)
      `CHK("sck in", ~a, ser_sck_i)
      @(posedge sys_clk);
    end
    acc(2'h0, ADDR_REMAP, 8'hC3);
    tm_pulse(MODE_COMPARE, FUNC_CMP_TOGGLE, 3'h1, 1'b0);
    tchk(1'b1);
    tm_pulse(MODE_COMPARE, FUNC_CMP_TOGGLE, 3'h2, 1'b0);
    tchk(1'b0);
    tm_pulse(MODE_COMPARE, FUNC_CMP_HIGH, 3'h2, 1'b0);
    tchk(1'b1);
    tm_pulse(MODE_COMPARE, FUNC_CMP_LOW, 3'h2, 1'b0);
    tchk(1'b0);
    tm_pulse(MODE_COMPARE, FUNC_CMP_TOGGLE, 3'h4, 1'b0);
    tchk(1'b0);
    for (k = 0; k < 5; k++)
    begin
      tm_pulse(MODE_PWM, (k < 2) ? 2'(k) : (k < 4) ? FUNC_PWM_WAVE : FUNC_PWM_PULSE, 3'h0, k[0]);
      tchk((k == 0) || (k == 3) || (k == 4));
    end
    acc(2'h0, ADDR_REMAP, 8'h03);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("timer pins off", 3'h2, {pa_oe[2], pa_oe[7], pa_out[7]})
    acc(2'h0, ADDR_REMAP, 8'h00);
    ser_enable <= 1'b0;
    ext_val <= 8'hFF;
    for (k = 0; k < 2; k++)
    begin
      @(posedge sys_clk);
      tm_clk_sel <= (k == 1) ? CLKSEL_EXT_FALL : CLKSEL_EXT_RISE;
      pin_ev(PIN_EXT_CLK, 1'b0, 0, k);
      pin_ev(PIN_EXT_CLK, 1'b1, 0, 1 - k);
    end
    tm_clk_sel <= 3'h0;
    tm_mode <= MODE_PWM;
    tm_pin_func <= FUNC_PWM_PULSE;
    pin_ev(PIN_EXT_CLK, 1'b0, 1, 0);
    pin_ev(PIN_EXT_CLK, 1'b1, 1, 1);
    tm_mode <= MODE_CAPTURE;
    for (k = 0; k < 3; k++)
    begin
      tm_pin_func <= 2'(k);
      pin_ev(PIN_CAPTURE, 1'b0, 2, k != 0);
      pin_ev(PIN_CAPTURE, 1'b1, 2, k != 1);
    end
    tm_cap_from_clk <= 1'b1;
    tm_pin_func <= FUNC_CAP_FALL;
    pin_ev(PIN_EXT_CLK, 1'b0, 2, 1);
    pin_ev(PIN_CAPTURE, 1'b0, 2, 0);
    tm_mode <= MODE_COMPARE;
    ext_val <= 8'hFF;
    k = $urandom_range(5, 0);
    pi = pins[k];
    pj = pins[(k + 1) % 6];
    acc(2'h0, ADDR_WAKE, 8'h01 << pi);
    sleeping <= 1'b1;
    pin_ev(pj, 1'b0, 5, 0);
    pin_ev(pi, 1'b0, 5, 1);
    pin_ev(pi, 1'b1, 5, 0);
    sleeping <= 1'b0;
    pin_ev(pi, 1'b0, 5, 0);
    rd(ADDR_WAKE, rv);
    `CHK("wake enable", 8'h01 << pi, rv)
    print_verdict();
  end
endmodule // timer_and_serial_pin_routing_test
